// >>> rtl/lrsc_line_rx_status.v
// receive line status, latched events, interrupt and counters
`timescale 1ns/10ps
`include "lrsc_consts.vh"

module lrsc_line_rx_status (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // decoder event inputs, same clock
    input  wire        signalLossRaw,
    input  wire        violationPulse,
    input  wire        lineCodingViolationPulse,
    input  wire        zeroRunPulse,
    input  wire        codewordPulse,
    input  wire        b3zsMode,
    input  wire        perfMonitorUpdate,
    // control to decoder
    output reg         rxSuppressionDecodeOff,
    output reg         e3CodingViolationSelect,
    // interrupt
    output reg         irq
);

// ------------------------------------------------------------
// register state
// ------------------------------------------------------------
reg  [15:0] ctrl_r;
reg  [15:0] gie_r;
reg  [15:0] mask_r;
reg  [5:0]  latch_r;
reg  [15:0] vAcc_r;
reg  [15:0] zAcc_r;
reg  [15:0] vCnt_r;
reg  [15:0] zCnt_r;
reg         lossLive_r;
reg         vNzPrev_r;
reg         zNzPrev_r;
reg         wrPend_r;
reg  [11:0] wrAddr_r;

// ------------------------------------------------------------
// bus decode
// ------------------------------------------------------------
wire        addrPhase;
wire        rdTake;
wire        wrTake;
wire        wrLatch;
wire [5:0]  w1cMask;
wire [5:0]  rdClear;

assign addrPhase = hsel & hready & (htrans == `LRSC_HTRANS_NSEQ);
assign rdTake    = addrPhase & ~hwrite;
assign wrTake    = addrPhase & hwrite;
assign wrLatch   = wrPend_r & (wrAddr_r == `LRSC_ADDR_LATCH);

assign w1cMask = wrLatch ? hwdata[5:0] : 6'h00;
assign rdClear = (rdTake && haddr == `LRSC_ADDR_LATCH) ? latch_r : 6'h00;

always @(posedge clk) begin
    if (rst) begin
        wrPend_r <= 1'b0;
        wrAddr_r <= 12'h000;
    end else begin
        wrPend_r <= wrTake;
        wrAddr_r <= haddr;
    end
end

// ------------------------------------------------------------
// software control registers
// ------------------------------------------------------------
always @(posedge clk) begin
    if (rst) begin
        ctrl_r <= `LRSC_RST_REG16;
        gie_r  <= `LRSC_RST_REG16;
        mask_r <= `LRSC_RST_REG16;
    end else if (wrPend_r) begin
        if (wrAddr_r == `LRSC_ADDR_CTRL) begin
            ctrl_r <= hwdata[15:0];
        end
        if (wrAddr_r == `LRSC_ADDR_GIE) begin
            gie_r <= hwdata[15:0];
        end
        if (wrAddr_r == `LRSC_ADDR_MASK) begin
            mask_r <= hwdata[15:0];
        end
    end
end

// ------------------------------------------------------------
// decoder control
// ------------------------------------------------------------
wire decodeOff;
wire e3Sel;

assign decodeOff = ctrl_r[`LRSC_CTRL_DECOFF];
assign e3Sel     = ctrl_r[`LRSC_CTRL_E3SEL];

always @(posedge clk) begin
    if (rst) begin
        rxSuppressionDecodeOff  <= 1'b0;
        e3CodingViolationSelect <= 1'b0;
    end else begin
        rxSuppressionDecodeOff  <= decodeOff;
        e3CodingViolationSelect <= e3Sel;
    end
end

// ------------------------------------------------------------
// live status
// ------------------------------------------------------------
wire lossNxt;
wire vNz;
wire zNz;
wire vioEvt;

// loss forced off while decoding off
assign lossNxt = signalLossRaw & ~decodeOff;

assign vNz = (vAcc_r != `LRSC_RST_REG16);

assign zNz = (zAcc_r != `LRSC_RST_REG16);

// lcv counted in e3 mode only
assign vioEvt = (e3Sel & ~b3zsMode) ? lineCodingViolationPulse : violationPulse;

always @(posedge clk) begin
    if (rst) begin
        lossLive_r <= 1'b0;
        vNzPrev_r  <= 1'b0;
        zNzPrev_r  <= 1'b0;
    end else begin
        lossLive_r <= lossNxt;
        vNzPrev_r  <= vNz;
        zNzPrev_r  <= zNz;
    end
end

// ------------------------------------------------------------
// event detection
// ------------------------------------------------------------
wire [5:0] evtSet;

assign evtSet[`LRSC_EV_LOSS]  = lossNxt ^ lossLive_r;
assign evtSet[`LRSC_EV_VRISE] = vNz & ~vNzPrev_r;
assign evtSet[`LRSC_EV_VIOL]  = vioEvt;
assign evtSet[`LRSC_EV_ZRISE] = zNz & ~zNzPrev_r;
assign evtSet[`LRSC_EV_ZRUN]  = zeroRunPulse;
// codeword seen, none when decode off
assign evtSet[`LRSC_EV_CODE]  = codewordPulse & ~decodeOff;

// ------------------------------------------------------------
// latched flags
// ------------------------------------------------------------
genvar gi;
generate
    for (gi = 0; gi < `LRSC_NUM_EV; gi = gi + 1) begin : gFlag
        always @(posedge clk) begin
            if (rst) begin
                latch_r[gi] <= 1'b0;
            end else if (evtSet[gi]) begin
                latch_r[gi] <= 1'b1;
            end else if (w1cMask[gi] | rdClear[gi]) begin
                latch_r[gi] <= 1'b0;
            end
        end
    end
endgenerate

// ------------------------------------------------------------
// interrupt
// ------------------------------------------------------------
wire irqNxt;

assign irqNxt = gie_r[`LRSC_GIE_PORT] & (|(latch_r & mask_r[5:0]));

always @(posedge clk) begin
    if (rst) begin
        irq <= 1'b0;
    end else begin
        irq <= irqNxt;
    end
end

// ------------------------------------------------------------
// performance counters
// ------------------------------------------------------------
wire [15:0] vInc;
wire [15:0] zInc;
wire [16:0] vSum;
wire [16:0] zSum;

// sums carry one spare bit, cut back to the counter width below
assign vSum = {1'b0, vAcc_r} + 17'h0_0001;
assign zSum = {1'b0, zAcc_r} + 17'h0_0001;

// accumulators saturate instead of wrapping
assign vInc = (vAcc_r == `LRSC_CNT_MAX) ? vAcc_r : vSum[15:0];
assign zInc = (zAcc_r == `LRSC_CNT_MAX) ? zAcc_r : zSum[15:0];

always @(posedge clk) begin
    if (rst) begin
        vAcc_r <= `LRSC_RST_REG16;
        vCnt_r <= `LRSC_RST_REG16;
    end else if (perfMonitorUpdate) begin
        vCnt_r <= vioEvt ? vInc : vAcc_r;
        vAcc_r <= `LRSC_RST_REG16;
    end else if (vioEvt) begin
        vAcc_r <= vInc;
    end
end

always @(posedge clk) begin
    if (rst) begin
        zAcc_r <= `LRSC_RST_REG16;
        zCnt_r <= `LRSC_RST_REG16;
    end else if (perfMonitorUpdate) begin
        zCnt_r <= zeroRunPulse ? zInc : zAcc_r;
        zAcc_r <= `LRSC_RST_REG16;
    end else if (zeroRunPulse) begin
        zAcc_r <= zInc;
    end
end

// ------------------------------------------------------------
// read mux
// ------------------------------------------------------------
reg [15:0] rdMux;

always @* begin
    rdMux = 16'h0000;
    case (haddr)
        `LRSC_ADDR_CTRL: begin
            rdMux = ctrl_r;
        end
        `LRSC_ADDR_GIE: begin
            rdMux = gie_r;
        end
        `LRSC_ADDR_LIVE: begin
            rdMux[`LRSC_LIVE_LOSS] = lossLive_r;
            rdMux[`LRSC_LIVE_VNZ]  = vNz;
            rdMux[`LRSC_LIVE_ZNZ]  = zNz;
        end
        `LRSC_ADDR_LATCH: begin
            rdMux[5:0] = latch_r;
        end
        `LRSC_ADDR_MASK: begin
            rdMux = mask_r;
        end
        `LRSC_ADDR_VCNT: begin
            rdMux = vCnt_r;
        end
        `LRSC_ADDR_ZCNT: begin
            rdMux = zCnt_r;
        end
        default: begin
            rdMux = 16'h0000;
        end
    endcase
end

// ------------------------------------------------------------
// bus answer
// ------------------------------------------------------------
always @(posedge clk) begin
    if (rst) begin
        hrdata    <= 32'h0000_0000;
        hreadyout <= 1'b0;
        hresp     <= 1'b0;
    end else begin
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
        if (rdTake) begin
            hrdata <= {16'h0000, rdMux};
        end
    end
end

endmodule

// >>> rtl/lrsc_consts.vh
// constants for the line receive status and counter block
`ifndef LRSC_CONSTS_VH
`define LRSC_CONSTS_VH

// register indices, byte address is four times the index
`define LRSC_IDX_CTRL    10'h090
`define LRSC_IDX_LIVE    10'h094
`define LRSC_IDX_LATCH   10'h096
`define LRSC_IDX_MASK    10'h098
`define LRSC_IDX_VCNT    10'h09C
`define LRSC_IDX_ZCNT    10'h09E
`define LRSC_IDX_GIE     10'h08E
`define LRSC_ADDR_CTRL   {`LRSC_IDX_CTRL, 2'b00}
`define LRSC_ADDR_LIVE   {`LRSC_IDX_LIVE, 2'b00}
`define LRSC_ADDR_LATCH  {`LRSC_IDX_LATCH, 2'b00}
`define LRSC_ADDR_MASK   {`LRSC_IDX_MASK, 2'b00}
`define LRSC_ADDR_VCNT   {`LRSC_IDX_VCNT, 2'b00}
`define LRSC_ADDR_ZCNT   {`LRSC_IDX_ZCNT, 2'b00}
`define LRSC_ADDR_GIE    {`LRSC_IDX_GIE, 2'b00}

// field positions
`define LRSC_CTRL_DECOFF 0
`define LRSC_CTRL_E3SEL  3
`define LRSC_GIE_PORT    1
`define LRSC_LIVE_LOSS   0
`define LRSC_LIVE_VNZ    1
`define LRSC_LIVE_ZNZ    3
`define LRSC_EV_LOSS     0
`define LRSC_EV_VRISE    1
`define LRSC_EV_VIOL     2
`define LRSC_EV_ZRISE    3
`define LRSC_EV_ZRUN     4
`define LRSC_EV_CODE     5
`define LRSC_NUM_EV      6

// reset values and limits
`define LRSC_RST_REG16   16'h0000
`define LRSC_RST_EV      6'h00
`define LRSC_CNT_MAX     16'hFFFF
`define LRSC_HTRANS_NSEQ 2'b10

`endif

// >>> verification/lrsc_rx_props.sv
// assertions for the line receive status block
`timescale 1ns/10ps
module lrsc_rx_props (
    // clock, reset, bus
    input logic        clk,
    input logic        rst,
    input logic        hsel,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic        hready,
    input logic [31:0] hwdata,
    input logic [31:0] hrdata,
    input logic        hreadyout,
    input logic        hresp,
    // outputs to decoder and host
    input logic        rxSuppressionDecodeOff,
    input logic        e3CodingViolationSelect,
    input logic        irq
);
    wire rdA = hsel && hready && htrans == 2'b10 && !hwrite;
    wire wrA = hsel && hready && htrans == 2'b10 && hwrite;
    wire d0  = hwdata[0];
    wire d3  = hwdata[3];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_resp_okay: assert property (!hresp)
        else $error("response not okay");
    a_ready_nowait: assert property (!rst |=> hreadyout)
        else $error("wait state inserted");
    a_rdata_upper: assert property (hrdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_rdata_hold: assert property (!$past(rdA) |-> $stable(hrdata))
        else $error("read data moved without a read");
    a_decoff_write: assert property (
        $changed(rxSuppressionDecodeOff) |-> rxSuppressionDecodeOff == $past(d0, 2))
        else $error("decode off does not follow write");
    a_e3sel_write: assert property (
        $changed(e3CodingViolationSelect) |-> e3CodingViolationSelect == $past(d3, 2))
        else $error("lcv select does not follow write");
    a_ctrl_hold: assert property (!$past(wrA, 3) |->
        $stable(rxSuppressionDecodeOff) && $stable(e3CodingViolationSelect))
        else $error("control moved without a write");
    a_irq_reset_low: assert property ($fell(rst) |-> !irq)
        else $error("irq high out of reset");
    cover property ($rose(irq));
    cover property (rdA);
    cover property ($rose(rxSuppressionDecodeOff));
endmodule

bind lrsc_line_rx_status lrsc_rx_props u_props (.*);

// >>> verification/lrsc_line_rx_status_test.sv
// self-checking bench for the line receive status block
`timescale 1ns/10ps
`include "lrsc_consts.vh"
module lrsc_line_rx_status_test;
    logic        clk = 0, rst = 1, hwrite = 0, loss = 0, b3 = 0, rdPend = 0;
    logic [11:0] haddr = 0;
    logic [1:0]  htrans = 0;
    logic [31:0] hwdata = 0, q[$];
    logic [4:0]  ev = 0;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, decOff, e3Sel, irq;
    int          fail_count = 0, comparisons = 0, n, m;

    lrsc_line_rx_status dut (.clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .signalLossRaw(loss), .violationPulse(ev[0]), .lineCodingViolationPulse(ev[1]),
        .zeroRunPulse(ev[2]), .codewordPulse(ev[3]), .b3zsMode(b3),
        .perfMonitorUpdate(ev[4]), .rxSuppressionDecodeOff(decOff),
        .e3CodingViolationSelect(e3Sel), .irq(irq));

    // ----
    // tasks
    // ----
    task automatic chk(string what, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
        hwrite <= w;
        haddr <= a;
        htrans <= `LRSC_HTRANS_NSEQ;
        do @(posedge clk); while (!hreadyout);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (!hreadyout);
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e);
        q.push_back(e);
        bus(0, a, 0);
    endtask
    task automatic pu(logic [4:0] p, int k);
        repeat (k) begin
            ev <= p;
            @(posedge clk);
            ev <= 0;
            @(posedge clk);
        end
    endtask
    task automatic ci(logic e, string what);
        @(negedge clk);
        chk(what, e, irq);
        @(posedge clk);
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // read data checked against the oldest note
    always @(posedge clk) begin
        if (rdPend && hreadyout)
            chk("hrdata", q.pop_front(), hrdata);
        rdPend <= htrans == `LRSC_HTRANS_NSEQ && !hwrite && hreadyout;
    end
    initial forever #12.5 clk = ~clk;
    initial begin
        #50000;
        fail_count++;
        report_and_stop;
    end
    initial begin
        n = $urandom(32'hb172);
        repeat (2) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rd(`LRSC_ADDR_MASK, 0);
        rd(`LRSC_ADDR_VCNT, 0);
        rd(`LRSC_ADDR_ZCNT, 0);
        rd(12'h004, 0);
        n = $urandom & 32'h0000_003f;
        bus(1, `LRSC_ADDR_MASK, n);
        rd(`LRSC_ADDR_MASK, n);
        $display("registers done");
        bus(1, `LRSC_ADDR_GIE, 2);
        bus(1, `LRSC_ADDR_MASK, 32'h0000_003f);
        pu(5'b01101, 1);
        ci(1, "irq on event");
        rd(`LRSC_ADDR_LIVE, 32'h0000_000a);
        rd(`LRSC_ADDR_LATCH, 32'h0000_003e);
        ci(0, "irq after clear");
        bus(1, `LRSC_ADDR_GIE, 0);
        loss <= 1;
        pu(0, 2);
        ci(0, "irq port off");
        rd(`LRSC_ADDR_LIVE, 32'h0000_000b);
        rd(`LRSC_ADDR_LATCH, 1);
        bus(1, `LRSC_ADDR_MASK, 0);
        bus(1, `LRSC_ADDR_GIE, 2);
        pu(5'b01000, 1);
        ci(0, "irq masked");
        bus(1, `LRSC_ADDR_LATCH, 32'h0000_003f);
        rd(`LRSC_ADDR_LATCH, 0);
        $display("events done");
        pu(5'b10000, 1);
        n = 1 + $urandom % 8;
        m = 1 + $urandom % 8;
        pu(5'b00001, n);
        pu(5'b00100, m);
        rd(`LRSC_ADDR_VCNT, 1);
        rd(`LRSC_ADDR_ZCNT, 1);
        pu(5'b10000, 1);
        rd(`LRSC_ADDR_VCNT, n);
        rd(`LRSC_ADDR_ZCNT, m);
        rd(`LRSC_ADDR_LIVE, 1);
        $display("counters done");
        bus(1, `LRSC_ADDR_CTRL, 1);
        @(posedge clk);
        @(negedge clk);
        chk("decode off", 1, decOff);
        rd(`LRSC_ADDR_LIVE, 0);
        rd(`LRSC_ADDR_LATCH, 32'h0000_001f);
        bus(1, `LRSC_ADDR_CTRL, 8);
        @(posedge clk);
        @(negedge clk);
        chk("lcv select", 1, e3Sel);
        @(posedge clk);
        for (int i = 0; i < 2; i++) begin
            b3 <= i;
            pu(5'b00001, 1);
            pu(5'b00010, 2);
            pu(5'b10000, 1);
            rd(`LRSC_ADDR_VCNT, 2 - i);
        end
        $display("modes done");
        pu(0, 2);
        report_and_stop;
    end
endmodule
